// ==== core/sof_formatter.v ====
// Gain, format and serialise eight converter channels onto LVDS-style lanes
`timescale 1ns/1ps
`include "sof_defines.vh"

// ==================================================================
// Sample FIFO
module sof_fifo #(
  parameter W = 104,
  parameter D = 4,
  parameter AW = 2
) (
  input  wire         clk,        // Clock
  input  wire         rst_n,      // Async reset
  input  wire [W-1:0] in_data,    // Write word
  input  wire         in_valid,   // Write request
  output wire         in_ready,   // Room available
  output wire [W-1:0] out_data,   // Head word
  output wire         out_valid,  // Not empty
  input  wire         out_ready   // Pop request
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  // Pointers and fill count
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
  // Storage
  always @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end
endmodule // sof_fifo

// ==================================================================
// Formatter top
module sof_formatter #(
  parameter CH = 8,
  parameter SW = 13,
  parameter BIT_DIV = 4,
  parameter FIFO_D = 4
) (
  input  wire           ref_clk,          // 125 MHz clock
  input  wire           reset_n,          // Async reset, active low
  input  wire           spi_sclk,         // Serial control clock
  input  wire           spi_cs_n,         // Serial control select, active low
  input  wire           spi_sdata,        // Serial control data
  input  wire [CH*SW-1:0] sample_data,    // Channel 0 in low bits
  input  wire           sample_valid,     // Sample set present
  output reg            sample_ready,     // FIFO has room
  output reg  [CH-1:0]  lane_data,        // Serial data lanes
  output reg            frame_clock_pos,  // Frame clock
  output reg            bit_clock,        // Forwarded bit clock
  output reg  [5:0]     fullscale_trim    // Analog range trim
);
  // ================================================================
  // Functions
  function [16:0] gain_coef;
    input [3:0] g;
    begin
      case (g)
        4'h1: gain_coef = 17'h011f4;
        4'h2: gain_coef = 17'h01425;
        4'h3: gain_coef = 17'h0169a;
        4'h4: gain_coef = 17'h0195c;
        4'h5: gain_coef = 17'h01c74;
        4'h6: gain_coef = 17'h01fed;
        4'h7: gain_coef = 17'h023d2;
        4'h8: gain_coef = 17'h02831;
        4'h9: gain_coef = 17'h02d19;
        4'ha: gain_coef = 17'h03299;
        4'hb: gain_coef = 17'h038c5;
        4'hc: gain_coef = 17'h03fb2;
        default: gain_coef = 17'h01000; // 0 dB, reserved codes too
      endcase
    end
  endfunction

  function [SW-1:0] gain_apply;
    input [SW-1:0] x;
    input [3:0]    g;
    reg signed [13:0] c;
    reg signed [31:0] p;
    begin
      c = $signed({1'b0, x}) - `SOF_MID_CODE;
      p = c * $signed({1'b0, gain_coef(g)});
      p = p >>> 12;
      if (p > $signed({{19{1'b0}}, `SOF_POS_MAX}))
        gain_apply = {1'b1, {(SW-1){1'b1}}};
      else if (p < $signed({{19{1'b1}}, `SOF_NEG_MIN}))
        gain_apply = {SW{1'b0}};
      else
        gain_apply = p[SW-1:0] ^ {1'b1, {(SW-1){1'b0}}};
    end
  endfunction

  // ================================================================
  // Serial control port
  reg [2:0]  sclk_q;
  reg [1:0]  cs_q;
  reg [1:0]  sd_q;
  reg [23:0] sh_q;
  reg [4:0]  cnt_q;
  reg [15:0] gain_lo_q;
  reg [15:0] gain_hi_q;
  reg [1:0]  phase_q;
  reg        btc_q;
  reg        msb_q;
  reg        sdr_q;
  reg        fall_q;
  reg        wide_q;
  reg        adv_q;
  reg        dly_q;
  wire [7:0]  wr_addr = sh_q[23:16];
  wire [15:0] wr_data = sh_q[15:0];
  wire        commit  = cs_q[1] && (cnt_q == `SOF_SPI_BITS);  // Write once select rises

  // Synchronise pins, shift on sampled rising clock edge
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h3;
      sd_q   <= 2'h0;
      sh_q   <= 24'h0;
      cnt_q  <= 5'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q   <= {cs_q[0], spi_cs_n};
      sd_q   <= {sd_q[0], spi_sdata};
      if (cs_q[1] || commit)
        cnt_q <= 5'h0;
      else if (sclk_q[1] && !sclk_q[2] && cnt_q != `SOF_SPI_BITS)
      begin
        sh_q  <= {sh_q[22:0], sd_q[1]};
        cnt_q <= cnt_q + 5'h1;
      end
    end
  end

  // Register writes after a full 24-bit frame
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gain_lo_q      <= 16'h0;
      gain_hi_q      <= 16'h0;
      phase_q        <= `SOF_PHASE_RST;
      btc_q          <= 1'b0;
      msb_q          <= 1'b0;
      sdr_q          <= 1'b0;
      fall_q         <= 1'b0;
      wide_q         <= 1'b0;
      adv_q          <= 1'b0;
      dly_q          <= 1'b0;
      fullscale_trim <= `SOF_TRIM_RST;
    end
    else if (commit)
    begin
      if (wr_addr == `SOF_ADDR_GAIN_LO)
        gain_lo_q <= wr_data;
      else if (wr_addr == `SOF_ADDR_GAIN_HI)
        gain_hi_q <= wr_data;
      else if (wr_addr == `SOF_ADDR_PHASE)
        phase_q <= wr_data[`SOF_PHASE_LSB+1:`SOF_PHASE_LSB];
      else if (wr_addr == `SOF_ADDR_FORMAT)
      begin
        btc_q  <= wr_data[`SOF_BTC_BIT];
        msb_q  <= wr_data[`SOF_MSB_BIT];
        sdr_q  <= wr_data[`SOF_SDR_BIT];
        fall_q <= wr_data[`SOF_FALL_BIT];
      end
      else if (wr_addr == `SOF_ADDR_WIDTH)
      begin
        wide_q <= wr_data[`SOF_NUM_BIT];
        adv_q  <= wr_data[`SOF_ADV_BIT];
        dly_q  <= wr_data[`SOF_DLY_BIT];
      end
      else if (wr_addr == `SOF_ADDR_TRIM)
        fullscale_trim <= wr_data[5:0];
    end
  end

  // ================================================================
  // Per-channel gain codes, channels 5..8 packed high to low
  wire [4*CH-1:0] gains = {gain_hi_q[3:0], gain_hi_q[7:4], gain_hi_q[11:8],
                           gain_hi_q[15:12], gain_lo_q};

  // ================================================================
  // Sample FIFO
  wire [CH*SW-1:0] head;
  wire             head_valid;
  wire             fifo_room;
  wire             load;
  sof_fifo #(.W(CH*SW), .D(FIFO_D), .AW(2)) u_fifo (
    .clk       (ref_clk),
    .rst_n     (reset_n),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (fifo_room),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (load)
  );

  // ================================================================
  // Word build: gain, code format, width
  reg  [13:0] word_q [0:CH-1];
  wire [13:0] word_d [0:CH-1];
  genvar gi;
  generate
    for (gi = 0; gi < CH; gi = gi + 1)
    begin : g_word
      wire [SW-1:0] raw = head_valid ? head[gi*SW +: SW] : {1'b1, {(SW-1){1'b0}}};
      wire [SW-1:0] gv  = gain_apply(raw, gains[gi*4 +: 4]);
      wire [SW-1:0] fv  = gv ^ {btc_q, {(SW-1){1'b0}}};
      assign word_d[gi] = wide_q ? {fv, 1'b0} : {2'b00, fv[SW-1:1]};
    end
  endgenerate

  // ================================================================
  // Bit timing
  reg  [1:0] sub_q;
  reg  [3:0] idx_q;
  reg        wide_f_q;
  reg        msb_f_q;
  wire [3:0] nbits    = wide_f_q ? `SOF_WORD_LONG : `SOF_WORD_SHORT;
  wire       slot_end = (sub_q == BIT_DIV[1:0] - 2'h1);
  assign load = slot_end && (idx_q == nbits - 4'h1);
  wire [3:0] sel      = msb_f_q ? nbits - 4'h1 - idx_q : idx_q;
  reg  [CH-1:0] cur_bits;
  integer li;
  // Current bit on each lane
  always @*
  begin
    cur_bits = {CH{1'b0}};
    for (li = 0; li < CH; li = li + 1)
      cur_bits[li] = word_q[li][sel];
  end
  wire cur_frame = (idx_q < {1'b0, nbits[3:1]});

  // Counters and word registers
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sub_q    <= 2'h0;
      idx_q    <= 4'h0;
      wide_f_q <= 1'b0;
      msb_f_q  <= 1'b0;
      for (li = 0; li < CH; li = li + 1)
        word_q[li] <= 14'h0;
    end
    else
    begin
      sub_q <= slot_end ? 2'h0 : sub_q + 2'h1;
      if (load)
      begin
        idx_q    <= 4'h0;
        wide_f_q <= wide_q;
        msb_f_q  <= msb_q;
        for (li = 0; li < CH; li = li + 1)
          word_q[li] <= word_d[li];
      end
      else if (slot_end)
        idx_q <= idx_q + 4'h1;
    end
  end

  // ================================================================
  // Shift history for advance and delay
  reg  [CH:0] hist_q [0:`SOF_HIST-1];
  wire [2:0]  lc_bits = sdr_q ? 3'h1 : 3'h2;
  wire [2:0]  tap     = adv_q ? 3'h0 :
                        dly_q ? {lc_bits[1:0], 1'b0} : lc_bits;
  integer hi;
  // History push once per bit slot
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      for (hi = 0; hi < `SOF_HIST; hi = hi + 1)
        hist_q[hi] <= {(CH+1){1'b0}};
    else if (slot_end)
    begin
      hist_q[0] <= {cur_frame, cur_bits};
      for (hi = 1; hi < `SOF_HIST; hi = hi + 1)
        hist_q[hi] <= hist_q[hi-1];
    end
  end

  // ================================================================
  // Output registers
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lane_data       <= {CH{1'b0}};
      frame_clock_pos <= 1'b0;
      bit_clock       <= 1'b0;
      sample_ready    <= 1'b0;
    end
    else
    begin
      sample_ready <= fifo_room;
      if (sub_q == 2'h0)
      begin
        lane_data       <= hist_q[tap][CH-1:0];
        frame_clock_pos <= hist_q[tap][CH];
      end
      // Bit clock from slot phase only, never from the tap
      if (sdr_q)
        bit_clock <= (sub_q >= `SOF_SDR_RISE) ^ fall_q;
      else if (sub_q == phase_q)
        bit_clock <= ~bit_clock;
    end
  end
endmodule // sof_formatter

// ==== core/sof_defines.vh ====
// Constants for the serial output formatter: rule summary, register map, fields, timing
// Function
// - Eight channels each own a four-bit gain
// - Gain codes 0..12 dB, 13..15 reserved
// - Double-rate bit clock is the default
// - Two-bit bit clock phase, reset 10
// - Single-rate bit clock runs twice as fast
// - Edge select centres rise or fall
// - Offset binary default, MSB invert for two's
// - LSB first by default, reversible
// - Width select: 0 gives 12, 1 gives 14
// - Drop LSB or append zero to 13 bits
// - Advance or delay lanes and frame one cycle
// - Bit clock unaffected by advance or delay
// - Six-bit full-scale trim, reset no change
`ifndef SOF_DEFINES_VH
`define SOF_DEFINES_VH
// ==================================================================
// Register addresses
`define SOF_ADDR_GAIN_LO   8'h2a
`define SOF_ADDR_GAIN_HI   8'h2b
`define SOF_ADDR_PHASE     8'h42
`define SOF_ADDR_FORMAT    8'h46
`define SOF_ADDR_WIDTH     8'h53
`define SOF_ADDR_TRIM      8'h55
// ==================================================================
// Field positions
`define SOF_PHASE_LSB      5
`define SOF_BTC_BIT        2
`define SOF_MSB_BIT        3
`define SOF_SDR_BIT        13
`define SOF_FALL_BIT       0
`define SOF_NUM_BIT        1
`define SOF_ADV_BIT        4
`define SOF_DLY_BIT        5
// ==================================================================
// Reset values
`define SOF_PHASE_RST      2'h2
`define SOF_TRIM_RST       6'h20
// ==================================================================
// Serial control frame and data path
`define SOF_SPI_BITS       5'h18
`define SOF_GAIN_MAX       4'hc
`define SOF_MID_CODE       14'sh1000
`define SOF_POS_MAX        13'sh0fff
`define SOF_NEG_MIN        13'sh1000
`define SOF_WORD_SHORT     4'hc
`define SOF_WORD_LONG      4'he
`define SOF_SDR_RISE       2'h2
`define SOF_HIST           5
`endif

// ==== tb/sof_checker.sv ====
// Checker for the formatter's serial outputs and trim field
`timescale 1ns/1ps
module sof_checker #(
  parameter BIT_DIV = 4
) (
  input wire       ref_clk,         // Clock
  input wire       reset_n,         // Reset, active low
  input wire       spi_cs_n,        // Control select
  input wire [7:0] lane_data,       // Lanes
  input wire       frame_clock_pos, // Frame clock
  input wire       bit_clock,       // Bit clock
  input wire [5:0] fullscale_trim   // Trim field
);
  reg [5:0] fl_q; // Cycles since frame edge
  reg [2:0] gp_q; // Cycles since bit clock edge
  reg       fr_q; // Last frame level
  reg       bc_q; // Last bit clock level
  reg       sf_q; // Frame edge seen
  reg       sc_q; // Bit clock edge seen
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==================================================================
  // Edge distance counters, saturating so a stuck output still fails
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fl_q <= 6'h00;
      gp_q <= 3'h0;
      fr_q <= 1'b0;
      bc_q <= 1'b0;
      sf_q <= 1'b0;
      sc_q <= 1'b0;
    end
    else
    begin
      fr_q <= frame_clock_pos;
      bc_q <= bit_clock;
      fl_q <= (frame_clock_pos != fr_q) ? 6'h01 : fl_q + {5'h00, fl_q != 6'h3f};
      gp_q <= (bit_clock != bc_q) ? 3'h1 : gp_q + {2'h0, gp_q != 3'h7};
      sf_q <= sf_q | (frame_clock_pos != fr_q);
      sc_q <= sc_q | (bit_clock != bc_q);
    end
  end
  // ==================================================================
  // Properties
  property p_frame_hi; $fell(frame_clock_pos) && sf_q |-> fl_q % BIT_DIV == 0 && fl_q <= 36; endproperty
  a_frame_hi: assert property (p_frame_hi) else $error("frame high off bit grid");
  property p_frame_lo; $rose(frame_clock_pos) && sf_q |-> fl_q % BIT_DIV == 0 && fl_q <= 36; endproperty
  a_frame_lo: assert property (p_frame_lo) else $error("frame low off bit grid");
  property p_clk_rise; $rose(frame_clock_pos) |=> $stable(bit_clock); endproperty
  a_clk_rise: assert property (p_clk_rise) else $error("bit clock moved with frame");
  property p_clk_phase; $rose(frame_clock_pos) |-> ##2 $changed(bit_clock); endproperty
  a_clk_phase: assert property (p_clk_phase) else $error("bit clock not mid-slot");
  property p_clk_gap; sc_q |-> gp_q <= BIT_DIV; endproperty
  a_clk_gap: assert property (p_clk_gap) else $error("bit clock edge missing");
  property p_lane_slot; $changed(lane_data) && sf_q |-> fl_q % BIT_DIV == 0; endproperty
  a_lane_slot: assert property (p_lane_slot) else $error("lane change off slot");
  property p_lane_hold; $changed(frame_clock_pos) |=> $stable(lane_data) [*3]; endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("lane bit too short");
  property p_trim_wr; $changed(fullscale_trim) |-> $past(spi_cs_n) && $past(spi_cs_n, 2); endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim changed in frame");
  c_frame: cover property ($rose(frame_clock_pos) && sf_q);
  c_trim: cover property ($changed(fullscale_trim));
  c_sdr: cover property (sc_q && bit_clock != bc_q && gp_q == 3'h2);
endmodule // sof_checker

bind sof_formatter sof_checker #(.BIT_DIV(BIT_DIV)) u_sof_checker (
  .ref_clk(ref_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .lane_data(lane_data),
  .frame_clock_pos(frame_clock_pos), .bit_clock(bit_clock), .fullscale_trim(fullscale_trim));

// ==== tb/sof_rx_model.sv ====
// Receiver model capturing one lane framed by the frame clock
`timescale 1ns/1ps
module sof_rx_model (
  input  wire        clk,   // Clock
  input  wire        rst_n, // Reset, active low
  input  wire        lane,  // Data lane
  input  wire        frame, // Frame clock
  output reg  [13:0] word,  // Bits, first in bit 0
  output reg  [3:0]  len,   // Bits in word
  output reg         done   // Word ready pulse
);
  reg        fr_q; // Last frame level
  reg [5:0]  t_q;  // Cycles since frame rise
  reg [13:0] sh_q; // Bits so far
  // ==================================================================
  // Restart at frame rise, take each bit in mid-window
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fr_q <= 1'b0;
      t_q  <= 6'h00;
      sh_q <= 14'h0000;
      word <= 14'h0000;
      len  <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      fr_q <= frame;
      done <= frame & ~fr_q;
      if (frame & ~fr_q)
      begin
        word <= sh_q;
        len  <= t_q[5:2];
        sh_q <= 14'h0000;
        t_q  <= 6'h01;
      end
      else
      begin
        t_q <= t_q + 6'h01;
        if (t_q[1:0] == 2'h1 && t_q[5:2] < 4'he)
          sh_q[t_q[5:2]] <= lane;
      end
    end
  end
endmodule // sof_rx_model

// ==== tb/testbench.sv ====
// Self-checking bench for the serial output formatter
`timescale 1ns/1ps
`include "sof_defines.vh"
module testbench;
  typedef struct packed {
    logic [15:0] fmt; // Format register
    logic [15:0] wid; // Width register
    logic [15:0] glo; // Gains 1..4
    logic [15:0] ghi; // Gains 5..8
    logic [12:0] smp; // Sample
    logic [12:0] cod; // Code after gain
    logic [2:0]  sel; // Lane watched
  } sof_row_t;
  reg          ref_clk;
  reg          reset_n;
  reg          spi_sclk;
  reg          spi_cs_n;
  reg          spi_sdata;
  reg  [103:0] sample_data;
  reg          sample_valid;
  reg  [2:0]   sel;
  wire         sample_ready;
  wire [7:0]   lane_data;
  wire         frame_clock_pos;
  wire         bit_clock;
  wire [5:0]   fullscale_trim;
  wire [13:0]  rx_word;
  wire [3:0]   rx_len;
  wire         rx_done;
  integer      err_count, n_compared, cyc, i, k;
  time         t0;
  sof_row_t    rows [0:10];
  sof_formatter u_sof_formatter (.ref_clk(ref_clk), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdata(spi_sdata), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .lane_data(lane_data),
    .frame_clock_pos(frame_clock_pos), .bit_clock(bit_clock), .fullscale_trim(fullscale_trim));
  sof_rx_model u_sof_rx_model (.clk(ref_clk), .rst_n(reset_n), .lane(lane_data[sel]),
    .frame(frame_clock_pos), .word(rx_word), .len(rx_len), .done(rx_done));
  // ==================================================================
  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  // ==================================================================
  // Tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task spi_wr(input [7:0] a, input [15:0] d);
    reg [23:0] f;
    integer    b;
    begin
      f = {a, d};
      @(negedge ref_clk);
      spi_cs_n = 1'b0;
      for (b = 23; b >= 0; b = b - 1)
      begin
        repeat (4) @(negedge ref_clk);
        spi_sclk  = 1'b0;
        spi_sdata = f[b];
        repeat (4) @(negedge ref_clk);
        spi_sclk = 1'b1;
      end
      repeat (4) @(negedge ref_clk);
      spi_cs_n  = 1'b1;
      spi_sclk  = 1'b0;
      spi_sdata = ~f[0];
      repeat (8) @(negedge ref_clk);
    end
  endtask
  task wait_words(input integer n);
    begin
      repeat (n)
      begin
        @(negedge ref_clk);
        while (rx_done !== 1'b1) @(negedge ref_clk);
      end
    end
  endtask
  function [15:0] exp_w(input [12:0] c, input btc, input msb, input n14);
    reg [13:0] w;
    integer    nb, j;
    begin
      nb = n14 ? 14 : 12;
      w = n14 ? {c[12] ^ btc, c[11:0], 1'b0} : {2'h0, c[12] ^ btc, c[11:1]};
      exp_w = {2'h0, w};
      for (j = 0; j < nb; j = j + 1)
        if (msb)
          exp_w[j] = w[nb - 1 - j];
    end
  endfunction
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ==================================================================
  // Main sequence
  initial
  begin
    {reset_n, spi_sclk, spi_sdata, sample_valid, sel} = 7'h00;
    spi_cs_n = 1'b1;
    sample_data = {8{13'h1000}};
    {err_count, n_compared, cyc} = 96'h0;
    rows[0] = '{16'h0, 16'h0, 16'h0, 16'h0, 13'h0a5b, 13'h0a5b, 3'h0};
    rows[1] = '{16'h4, 16'h0, 16'h0, 16'h0, 13'h0a5b, 13'h0a5b, 3'h0};
    rows[2] = '{16'h8, 16'h0, 16'h0, 16'h0, 13'h0a5b, 13'h0a5b, 3'h0};
    rows[3] = '{16'h0, 16'h2, 16'h0, 16'h0, 13'h0a5b, 13'h0a5b, 3'h0};
    rows[4] = '{16'hc, 16'h22, 16'h0, 16'h0, 13'h1234, 13'h1234, 3'h0};
    rows[5] = '{16'h2000, 16'h10, 16'h0, 16'h0, 13'h1234, 13'h1234, 3'h0};
    rows[6] = '{16'h2001, 16'h22, 16'h0, 16'h0, 13'h1234, 13'h1234, 3'h0};
    rows[7] = '{16'h0, 16'h0, 16'hc, 16'h0, 13'h1770, 13'h1fff, 3'h0};
    rows[8] = '{16'h0, 16'h0, 16'hc, 16'h1, 13'h1770, 13'h1858, 3'h7};
    rows[9] = '{16'h0, 16'h0, 16'hc, 16'h0, 13'h0000, 13'h0000, 3'h0};
    rows[10] = '{16'h8, 16'h12, 16'h0, 16'h0, 13'h1770, 13'h1770, 3'h0};
    repeat (5) @(negedge ref_clk);
    chk({lane_data, frame_clock_pos, bit_clock, sample_ready}, 16'h0);
    chk(fullscale_trim, 6'h20);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(sample_ready, 1'b1);
    sample_valid = 1'b1;
    k = 0;
    while (sample_ready !== 1'b0 && k < 60)
    begin
      @(negedge ref_clk);
      k = k + 1;
    end
    chk(k < 60, 1'b1);
    spi_wr(8'h30, 16'h3f);
    chk(fullscale_trim, 6'h20);
    spi_wr(`SOF_ADDR_TRIM, 16'h15);
    chk(fullscale_trim, 6'h15);
    // Advance and delay never set together; single rate kept to slow samples
    for (i = 0; i < 11; i = i + 1)
    begin
      sel = rows[i].sel;
      spi_wr(`SOF_ADDR_FORMAT, rows[i].fmt);
      spi_wr(`SOF_ADDR_WIDTH, rows[i].wid);
      spi_wr(`SOF_ADDR_GAIN_LO, rows[i].glo);
      spi_wr(`SOF_ADDR_GAIN_HI, rows[i].ghi);
      sample_data = {8{rows[i].smp}};
      wait_words(7);
      chk(rx_len, rows[i].wid[1] ? 14 : 12);
      chk(rx_word, exp_w(rows[i].cod, rows[i].fmt[2], rows[i].fmt[3], rows[i].wid[1]));
      @(posedge bit_clock);
      t0 = $time;
      @(posedge bit_clock);
      chk(($time - t0) / 8, rows[i].fmt[13] ? 4 : 8);
      // Frame lag behind the word load, in bit slots of four cycles
      k = rows[i].wid[4] ? 0 : (rows[i].fmt[13] ? 1 : 2) * (rows[i].wid[5] ? 2 : 1);
      @(posedge sample_ready);
      t0 = $time;
      @(posedge frame_clock_pos);
      chk(($time - t0) / 8, 4 + 4 * k);
      @(negedge ref_clk);
      if (rows[i].fmt[13])
        chk(bit_clock, rows[i].fmt[0]);
    end
    sample_valid = 1'b0;
    wait_words(7);
    chk(rx_word, exp_w(13'h1000, 1'b0, 1'b1, 1'b1));
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk({lane_data, fullscale_trim}, 14'h0020);
    reset_n = 1'b1;
    stop_test;
  end
endmodule // testbench
